/* File: design/carrier_sense_gain_freeze_ctrl.sv */
// Function
// - assert after cs_assert_count+1 samples at/above level
// - carrier sense drives status pin when enabled
// - clear after one or two samples below
// - hold codes 0-6 give 16..48 filter clocks
// - hold code 7 freezes levels indefinitely
// - freeze loops after set switch, unlock, power-up
// - extra freeze 16/32/64/128 converter clocks
// - floor is minimum or medium gain
// - ceiling is medium or maximum gain
// - strength sample averages 2/4/8/16 magnitudes
// - filter clock is converter clock over divisor plus one
`timescale 1ns/1ps
`default_nettype none

module carrier_sense_gain_freeze_ctrl
  import cs_freeze_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        ADC_CLK_IN,
  input  wire logic        MAG_VALID_IN,
  input  wire logic [7:0]  MAG_IN,
  input  wire logic        FREQ_SET_SWITCH_IN,
  input  wire logic        PLL_UNLOCK_IN,
  input  wire logic        RX_POWERUP_IN,
  input  wire logic [1:0]  LNA_GAIN_REQ_IN,
  output logic             CARRIER_SENSE_OUT,
  output logic             STATUS_PIN_OUT,
  output logic [7:0]       RSSI_OUT,
  output logic             FREEZE_OUT,
  output logic [1:0]       LNA_GAIN_OUT,
  output logic             IRQ_OUT
);

  hold_cfg_s   hold_cfg_q, hold_cfg_d;
  gain_cfg_s   gain_cfg_q, gain_cfg_d;
  logic [11:0] ctrl_q, ctrl_d;
  logic [2:0]  irq_st_q, irq_st_d;
  logic [2:0]  irq_mask_q, irq_mask_d;
  logic        irq_q, irq_d;
  logic        wr_pend_q, wr_pend_d;
  logic [5:0]  wr_idx_q, wr_idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q;
  logic        resp_q;
  logic [2:0]  irq_ev;
  logic [5:0]  a_idx;
  logic        a_take;

  logic        adc_s1_q, adc_s2_q, adc_s3_q;
  logic        adc_tick;
  logic [2:0]  fdiv_q, fdiv_d;
  logic        ftick;

  logic [11:0] acc_q, acc_d;
  logic [4:0]  nsmp_q, nsmp_d;
  logic [7:0]  rssi_q, rssi_d;
  logic        smp_q, smp_d;
  logic [11:0] acc_sum;
  logic [4:0]  nsmp_inc;

  logic        cs_q, cs_d;
  logic [2:0]  above_q, above_d;
  logic [1:0]  below_q, below_d;
  logic        pin_q, pin_d;

  logic [5:0]  wait_q, wait_d;
  logic [7:0]  extra_q, extra_d;
  logic        frz_q, frz_d;
  logic        trig;

  logic [1:0]  lna_q, lna_d;
  logic        chg_q, chg_d;
  logic [1:0]  g_floor, g_ceil, g_tgt;

  // bus
  assign a_idx  = HADDR_IN[7:2];
  assign a_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN && (HADDR_IN[31:8] == 24'h00_0000);

  always_comb begin
    hold_cfg_d = hold_cfg_q;
    gain_cfg_d = gain_cfg_q;
    ctrl_d     = ctrl_q;
    irq_mask_d = irq_mask_q;
    wr_pend_d  = a_take && HWRITE_IN;
    wr_idx_d   = a_idx;
    rdata_d    = 32'h0000_0000;
    irq_st_d   = irq_st_q;
    if (wr_pend_q) begin
      unique case (wr_idx_q)
        IDX_HOLD_CFG:   hold_cfg_d = HWDATA_IN[7:0];
        IDX_GAIN_CFG:   gain_cfg_d = HWDATA_IN[7:0];
        IDX_CTRL:       ctrl_d     = HWDATA_IN[11:0];
        IDX_IRQ_STATUS: irq_st_d   = irq_st_q & ~HWDATA_IN[2:0];
        IDX_IRQ_MASK:   irq_mask_d = HWDATA_IN[2:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    irq_st_d = irq_st_d | irq_ev;
    if (a_take && !HWRITE_IN) begin
      unique case (a_idx)
        IDX_HOLD_CFG:   rdata_d[7:0]  = hold_cfg_q;
        IDX_GAIN_CFG:   rdata_d[7:0]  = gain_cfg_q;
        IDX_CTRL:       rdata_d[11:0] = ctrl_q;
        IDX_STATUS: begin
          rdata_d[STAT_CS_BIT]                  = cs_q;
          rdata_d[STAT_FRZ_BIT]                 = frz_q;
          rdata_d[STAT_GAIN_LSB +: 2]           = lna_q;
          rdata_d[STAT_RSSI_LSB +: 8]           = rssi_q;
        end
        IDX_IRQ_STATUS: rdata_d[2:0]  = irq_st_q;
        IDX_IRQ_MASK:   rdata_d[2:0]  = irq_mask_q;
        default: ;
      endcase
    end
    irq_d = |(irq_st_d & irq_mask_d);
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      hold_cfg_q <= HOLD_CFG_RST;
      gain_cfg_q <= GAIN_CFG_RST;
      ctrl_q     <= CTRL_RST;
      irq_st_q   <= 3'h0;
      irq_mask_q <= IRQ_MASK_RST;
      irq_q      <= 1'b0;
      wr_pend_q  <= 1'b0;
      wr_idx_q   <= 6'h00;
      rdata_q    <= 32'h0000_0000;
      ready_q    <= 1'b0;
      resp_q     <= 1'b0;
    end else begin
      hold_cfg_q <= hold_cfg_d;
      gain_cfg_q <= gain_cfg_d;
      ctrl_q     <= ctrl_d;
      irq_st_q   <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
      wr_pend_q  <= wr_pend_d;
      wr_idx_q   <= wr_idx_d;
      rdata_q    <= rdata_d;
      // zero wait states; always okay
      ready_q    <= 1'b1;
      resp_q     <= 1'b0;
    end
  end

  // converter clock pin: two stages before the edge detector
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      adc_s1_q <= 1'b0;
      adc_s2_q <= 1'b0;
      adc_s3_q <= 1'b0;
    end else begin
      adc_s1_q <= ADC_CLK_IN;
      adc_s2_q <= adc_s1_q;
      adc_s3_q <= adc_s2_q;
    end
  end
  assign adc_tick = adc_s2_q && !adc_s3_q;

  // filter clock: one per divisor-plus-one converter clocks
  assign ftick = adc_tick && (fdiv_q == ctrl_q[CTRL_DIV_LSB +: 3]);
  always_comb begin
    fdiv_d = fdiv_q;
    if (ftick) begin
      fdiv_d = 3'h0;
    end else if (adc_tick) begin
      fdiv_d = fdiv_q + 3'h1;
    end
  end

  // magnitude averaging, held while frozen
  assign acc_sum  = acc_q + {4'h0, MAG_IN};
  assign nsmp_inc = nsmp_q + 5'h01;
  always_comb begin
    acc_d  = acc_q;
    nsmp_d = nsmp_q;
    rssi_d = rssi_q;
    smp_d  = 1'b0;
    if (MAG_VALID_IN && !frz_q) begin
      if (nsmp_inc == (AVG_BASE << gain_cfg_q.magnitude_average_len)) begin
        acc_d  = 12'h000;
        nsmp_d = 5'h00;
        // widened sum so code 3 shifts by four instead of wrapping to zero
        rssi_d = 8'(acc_sum >> ({1'b0, gain_cfg_q.magnitude_average_len} + 3'h1));
        smp_d  = 1'b1;
      end else begin
        acc_d  = acc_sum;
        nsmp_d = nsmp_inc;
      end
    end
  end

  // carrier sense qualification
  always_comb begin
    cs_d    = cs_q;
    above_d = above_q;
    below_d = below_q;
    if (smp_q) begin
      if (rssi_q >= ctrl_q[CTRL_LEVEL_LSB +: 8]) begin
        below_d = 2'h0;
        if (!cs_q) begin
          if (above_q == {1'b0, hold_cfg_q.cs_assert_count}) begin
            cs_d    = 1'b1;
            above_d = 3'h0;
          end else begin
            above_d = above_q + 3'h1;
          end
        end
      end else begin
        above_d = 3'h0;
        if (cs_q) begin
          if (below_q == {1'b0, hold_cfg_q.cs_deassert_count}) begin
            cs_d    = 1'b0;
            below_d = 2'h0;
          end else begin
            below_d = below_q + 2'h1;
          end
        end
      end
    end
    pin_d = cs_d && ctrl_q[CTRL_PIN_BIT];
  end

  // freeze timers
  assign trig = FREQ_SET_SWITCH_IN || PLL_UNLOCK_IN || RX_POWERUP_IN;
  always_comb begin
    wait_d  = wait_q;
    extra_d = extra_q;
    if (trig) begin
      wait_d  = HOLD_FC[hold_cfg_q.gain_change_hold];
      extra_d = EXTRA_BASE << hold_cfg_q.extra_hold_time;
    end else begin
      if (chg_q) begin
        wait_d = HOLD_FC[hold_cfg_q.gain_change_hold];
      end else if (ftick && (wait_q != 6'h00)) begin
        wait_d = wait_q - 6'h01;
      end
      if (adc_tick && (extra_q != 8'h00)) begin
        extra_d = extra_q - 8'h01;
      end
    end
    frz_d = (hold_cfg_q.gain_change_hold == HOLD_FOREVER) ||
            (wait_d != 6'h00) || (extra_d != 8'h00);
  end

  // second low-noise stage limits
  assign g_floor = gain_cfg_q.lna_gain_floor ? LNA_MED : LNA_MIN;
  assign g_ceil  = gain_cfg_q.lna_gain_ceiling ? LNA_MAX : LNA_MED;
  always_comb begin
    if (LNA_GAIN_REQ_IN < g_floor) begin
      g_tgt = g_floor;
    end else if (LNA_GAIN_REQ_IN > g_ceil) begin
      g_tgt = g_ceil;
    end else begin
      g_tgt = LNA_GAIN_REQ_IN;
    end
    lna_d = lna_q;
    chg_d = 1'b0;
    // gain is held while frozen so the loops settle on a stable level
    if (!frz_q && (g_tgt != lna_q)) begin
      lna_d = g_tgt;
      chg_d = 1'b1;
    end
  end

  assign irq_ev[IRQ_CS_SET]  = cs_d && !cs_q;
  assign irq_ev[IRQ_CS_CLR]  = !cs_d && cs_q;
  assign irq_ev[IRQ_FRZ_END] = frz_q && !frz_d;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      fdiv_q  <= 3'h0;
      acc_q   <= 12'h000;
      nsmp_q  <= 5'h00;
      rssi_q  <= 8'h00;
      smp_q   <= 1'b0;
      cs_q    <= 1'b0;
      above_q <= 3'h0;
      below_q <= 2'h0;
      pin_q   <= 1'b0;
      wait_q  <= 6'h00;
      extra_q <= 8'h00;
      frz_q   <= 1'b0;
      lna_q   <= LNA_MIN;
      chg_q   <= 1'b0;
    end else begin
      fdiv_q  <= fdiv_d;
      acc_q   <= acc_d;
      nsmp_q  <= nsmp_d;
      rssi_q  <= rssi_d;
      smp_q   <= smp_d;
      cs_q    <= cs_d;
      above_q <= above_d;
      below_q <= below_d;
      pin_q   <= pin_d;
      wait_q  <= wait_d;
      extra_q <= extra_d;
      frz_q   <= frz_d;
      lna_q   <= lna_d;
      chg_q   <= chg_d;
    end
  end

  assign HRDATA_OUT        = rdata_q;
  assign HREADYOUT_OUT     = ready_q;
  assign HRESP_OUT         = resp_q;
  assign CARRIER_SENSE_OUT = cs_q;
  assign STATUS_PIN_OUT    = pin_q;
  assign RSSI_OUT          = rssi_q;
  assign FREEZE_OUT        = frz_q;
  assign LNA_GAIN_OUT      = lna_q;
  assign IRQ_OUT           = irq_q;

endmodule

`default_nettype wire

/* File: pkg/cs_freeze_pkg.sv */
package cs_freeze_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_HOLD_CFG   = 6'h11;
  localparam logic [5:0] IDX_GAIN_CFG   = 6'h12;
  localparam logic [5:0] IDX_CTRL       = 6'h18;
  localparam logic [5:0] IDX_STATUS     = 6'h19;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h1A;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h1B;

  localparam logic [7:0]  HOLD_CFG_RST = 8'h65;
  localparam logic [7:0]  GAIN_CFG_RST = 8'h75;
  localparam logic [11:0] CTRL_RST     = 12'h040;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

  // irq status bit positions
  localparam int IRQ_CS_SET  = 0;
  localparam int IRQ_CS_CLR  = 1;
  localparam int IRQ_FRZ_END = 2;

  // ctrl field positions
  localparam int CTRL_LEVEL_LSB = 0;
  localparam int CTRL_DIV_LSB   = 8;
  localparam int CTRL_PIN_BIT   = 11;

  // status field positions
  localparam int STAT_CS_BIT    = 0;
  localparam int STAT_FRZ_BIT   = 1;
  localparam int STAT_GAIN_LSB  = 2;
  localparam int STAT_RSSI_LSB  = 8;

  // hold lengths in filter clocks; code 7 freezes without end
  localparam logic [2:0] HOLD_FOREVER = 3'h7;
  localparam logic [5:0] HOLD_FC [0:7] = '{6'h10, 6'h14, 6'h18, 6'h1C,
                                           6'h20, 6'h28, 6'h30, 6'h00};
  // extra hold is this many converter clocks shifted left by its code
  localparam logic [7:0] EXTRA_BASE = 8'h10;
  localparam logic [4:0] AVG_BASE   = 5'h02;

  // second low-noise stage gain codes
  localparam logic [1:0] LNA_MIN = 2'h0;
  localparam logic [1:0] LNA_MED = 2'h1;
  localparam logic [1:0] LNA_MAX = 2'h2;

  typedef struct packed {
    logic [1:0] cs_assert_count;
    logic       cs_deassert_count;
    logic [2:0] gain_change_hold;
    logic [1:0] extra_hold_time;
  } hold_cfg_s;

  typedef struct packed {
    logic       lna_gain_floor;
    logic       lna_gain_ceiling;
    logic [1:0] lna_switch_point;
    logic       agc_disable;
    logic       agc_hysteresis;
    logic [1:0] magnitude_average_len;
  } gain_cfg_s;

endpackage

/* File: bench/cs_freeze_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cs_freeze_props (
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RESET_IN,
  input  wire logic       MAG_VALID_IN,
  input  wire logic       FREQ_SET_SWITCH_IN,
  input  wire logic       PLL_UNLOCK_IN,
  input  wire logic       RX_POWERUP_IN,
  input  wire logic       CARRIER_SENSE_OUT,
  input  wire logic       STATUS_PIN_OUT,
  input  wire logic [7:0] RSSI_OUT,
  input  wire logic       FREEZE_OUT,
  input  wire logic [1:0] LNA_GAIN_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  logic trig;
  assign trig = FREQ_SET_SWITCH_IN | PLL_UNLOCK_IN | RX_POWERUP_IN;
  pin_follows_a: assert property (STATUS_PIN_OUT |-> CARRIER_SENSE_OUT)
    else $error("status pin high without carrier sense");
  cs_timing_a: assert property ($changed(CARRIER_SENSE_OUT) |-> $past(MAG_VALID_IN, 2))
    else $error("carrier sense moved without a sample");
  cs_frozen_a: assert property ($changed(CARRIER_SENSE_OUT) |-> !$past(FREEZE_OUT, 2))
    else $error("carrier sense moved from a frozen sample");
  rssi_timing_a: assert property ($changed(RSSI_OUT) |-> $past(MAG_VALID_IN))
    else $error("strength moved without a sample");
  freeze_start_a: assert property (trig |=> FREEZE_OUT [*8])
    else $error("freeze not raised or too short");
  gain_frozen_a: assert property (FREEZE_OUT && $past(FREEZE_OUT) |-> $stable(LNA_GAIN_OUT))
    else $error("gain moved while frozen");
  rssi_frozen_a: assert property (FREEZE_OUT && $past(FREEZE_OUT) |-> $stable(RSSI_OUT))
    else $error("strength moved while frozen");
  gain_ceiling_a: assert property (LNA_GAIN_OUT != 2'h3)
    else $error("gain code out of range");
  cover property ($rose(FREEZE_OUT));
  cover property ($rose(CARRIER_SENSE_OUT));
  cover property ($fell(CARRIER_SENSE_OUT));
endmodule

bind carrier_sense_gain_freeze_ctrl cs_freeze_props props (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .MAG_VALID_IN(MAG_VALID_IN),
  .FREQ_SET_SWITCH_IN(FREQ_SET_SWITCH_IN), .PLL_UNLOCK_IN(PLL_UNLOCK_IN),
  .RX_POWERUP_IN(RX_POWERUP_IN), .CARRIER_SENSE_OUT(CARRIER_SENSE_OUT),
  .STATUS_PIN_OUT(STATUS_PIN_OUT), .RSSI_OUT(RSSI_OUT), .FREEZE_OUT(FREEZE_OUT),
  .LNA_GAIN_OUT(LNA_GAIN_OUT)
);
`default_nettype wire

/* File: bench/ahb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  int hangs = 0;
  assign hsize = 3'h2;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // bounded so a dead slave shows up as a counted hang
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 32);
    if (hready !== 1'b1) hangs++;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
endmodule
`default_nettype wire

/* File: bench/carrier_sense_gain_freeze_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module carrier_sense_gain_freeze_ctrl_tb_top;
  import cs_freeze_pkg::*;
  logic        clk, rst, mv, hsel, hwrite, ready, resp, cs, pin, frz, irq;
  logic [1:0]  htrans, lreq, lg, ph;
  logic [2:0]  hsize, trg;
  logic [7:0]  mag, rssi;
  logic [31:0] haddr, hwdata, hrdata;
  int          bad_count = 0;
  int          cmp_count = 0;
  logic [31:0] ra [5] = '{32'h44, 32'h48, 32'h60, 32'h6C, 32'h70};
  logic [31:0] re [5] = '{32'(HOLD_CFG_RST), 32'(GAIN_CFG_RST), 32'(CTRL_RST), 32'h0, 32'h0};
  logic [7:0]  runs [5] = '{8'h40, 8'h40, 8'h3F, 8'h40, 8'h40};
  logic [2:0]  hc [5] = '{3'h0, 3'h5, 3'h0, 3'h6, 3'h0};
  logic [1:0]  ec [5] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h0};
  // converter ticks; the last run halves the filter clock
  int          tk [5] = '{16, 40, 128, 48, 32};

  carrier_sense_gain_freeze_ctrl dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(ready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(ready), .HRESP_OUT(resp),
    .ADC_CLK_IN(ph[1]), .MAG_VALID_IN(mv), .MAG_IN(mag), .FREQ_SET_SWITCH_IN(trg[0]),
    .PLL_UNLOCK_IN(trg[1]), .RX_POWERUP_IN(trg[2]), .LNA_GAIN_REQ_IN(lreq),
    .CARRIER_SENSE_OUT(cs), .STATUS_PIN_OUT(pin), .RSSI_OUT(rssi), .FREEZE_OUT(frz),
    .LNA_GAIN_OUT(lg), .IRQ_OUT(irq));
  ahb_host_model host (.clk(clk), .hready(ready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // converter clock at a quarter rate, slow enough for the two-flop sync
  always @(posedge clk) ph <= ph + 2'h1;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [31:0] a, exp);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0, r);
    chk("register", r, exp);
    chk("resp", 32'(resp), 32'h0);
  endtask
  // one averaged sample: two filter outputs back to back
  task automatic smp(input logic [7:0] m);
    repeat (2) begin
      mv <= 1'b1;
      mag <= m;
      @(posedge clk);
    end
    mv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic gn(input logic [1:0] req, exp);
    int n;
    lreq <= req;
    repeat (3) @(posedge clk);
    chk("gain", 32'(lg), 32'(exp));
    n = 0;
    while (frz !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("unfrozen", 32'(frz), 32'h0);
  endtask
  task automatic conclude();
    bad_count += host.hangs;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    int n;
    rst = 1'b1;
    mv = 1'b0;
    mag = 8'h0;
    trg = 3'h0;
    lreq = 2'h0;
    ph = 2'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ra[i]) rc(ra[i], re[i]);
    wr(32'h70, 32'hFFFF_FFFF);
    rc(32'h70, 32'h0);
    wr(32'h48, 32'h40);
    rc(32'h48, 32'h40);
    wr(32'h6C, 32'h3);
    wr(32'h60, 32'h840);
    gn(2'h2, 2'h2);
    gn(2'h3, 2'h2);
    wr(32'h48, 32'h80);
    gn(2'h2, 2'h1);
    gn(2'h0, 2'h1);
    wr(32'h48, 32'h40);
    gn(2'h0, 2'h0);
    wr(32'h44, 32'hA0);
    wr(32'h68, 32'h7);
    foreach (runs[i]) smp(runs[i]);
    chk("cs", 32'(cs), 32'h0);
    smp(8'h40);
    chk("cs", 32'(cs), 32'h1);
    chk("pin", 32'(pin), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rc(32'h64, 32'h0000_4001);
    smp(8'h3F);
    chk("cs", 32'(cs), 32'h1);
    smp(8'h3F);
    chk("cs", 32'(cs), 32'h0);
    rc(32'h68, 32'h3);
    wr(32'h68, 32'h3);
    rc(32'h68, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    wr(32'h48, 32'h43);
    repeat (7) smp(8'h20);
    chk("rssi", 32'(rssi), 32'h3F);
    smp(8'h20);
    chk("rssi", 32'(rssi), 32'h20);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(32'h60, 32'h940);
      wr(32'h44, {24'h0, 3'h5, hc[i], ec[i]});
      trg[i % 3] <= 1'b1;
      @(posedge clk);
      trg <= 3'h0;
      @(posedge clk);
      chk("freeze", 32'(frz), 32'h1);
      n = 0;
      while (frz === 1'b1 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      chk("hold", 32'(n + 2 >= tk[i] * 4 - 6 && n + 2 <= tk[i] * 4 + 8), 32'h1);
    end
    rc(32'h68, 32'h4);
    chk("irq", 32'(irq), 32'h0);
    wr(32'h44, 32'hBC);
    trg[0] <= 1'b1;
    @(posedge clk);
    trg <= 3'h0;
    repeat (300) @(posedge clk);
    chk("freeze", 32'(frz), 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
